/* File: icsc_pkg.sv */
// package: register map, field positions, reset values and state types of the interrupt status block
`default_nettype none
package icsc_pkg;

  localparam int unsigned ICSC_NSRC      = 32;
  localparam int unsigned ICSC_AW        = 12;

  // register byte offsets inside the 4 KB window
  localparam logic [11:0] ICSC_SVR_BASE  = 12'h080;
  localparam logic [11:0] ICSC_SVR_LAST  = 12'h0fc;
  localparam logic [11:0] ICSC_NVR_OFS   = 12'h100;
  localparam logic [11:0] ICSC_FVR_OFS   = 12'h104;
  localparam logic [11:0] ICSC_CSS_OFS   = 12'h108;
  localparam logic [11:0] ICSC_PND_OFS   = 12'h10c;
  localparam logic [11:0] ICSC_MSK_OFS   = 12'h110;
  localparam logic [11:0] ICSC_CLS_OFS   = 12'h114;
  localparam logic [11:0] ICSC_ENA_OFS   = 12'h120;
  localparam logic [11:0] ICSC_DIS_OFS   = 12'h124;
  localparam logic [11:0] ICSC_CLR_OFS   = 12'h128;
  localparam logic [11:0] ICSC_SET_OFS   = 12'h12c;
  localparam logic [11:0] ICSC_EOS_OFS   = 12'h130;
  localparam logic [11:0] ICSC_SPU_OFS   = 12'h134;
  localparam logic [11:0] ICSC_DBG_OFS   = 12'h138;
  localparam logic [11:0] ICSC_EVS_OFS   = 12'h150;
  localparam logic [11:0] ICSC_EVM_OFS   = 12'h154;

  // field positions
  localparam int unsigned ICSC_DBG_PROTECT     = 0;
  localparam int unsigned ICSC_DBG_GLOBAL_MASK = 1;
  localparam int unsigned ICSC_CLS_FAST  = 0;
  localparam int unsigned ICSC_CLS_NORM  = 1;
  localparam int unsigned ICSC_EV_EOS    = 0;
  localparam int unsigned ICSC_EV_SPUR   = 1;
  localparam int unsigned ICSC_NEV       = 2;

  // reset values
  localparam logic [31:0] ICSC_RST_WORD  = 32'h0000_0000;

  typedef enum logic [3:0] {
    ICSC_BUS_IDLE = 4'b0001,
    ICSC_BUS_WR   = 4'b0010,
    ICSC_BUS_RDW  = 4'b0100,
    ICSC_BUS_RDD  = 4'b1000
  } icsc_bus_st_t;

  // captured address phase
  typedef struct packed {
    logic [11:0] ofs;
  } icsc_aphase_t;

  typedef struct packed {
    icsc_bus_st_t              bus_st;
    icsc_aphase_t              aph;
    logic [31:0]               rdata;
    logic [ICSC_NSRC-1:0]      src_s1;
    logic [ICSC_NSRC-1:0]      src_s2;
    logic [ICSC_NSRC-1:0]      src_s3;
    logic [ICSC_NSRC-1:0]      pending;
    logic [ICSC_NSRC-1:0]      mask;
    logic [ICSC_NSRC-1:0][31:0] svr;
    logic [31:0]               spu;
    logic                      protect;
    logic                      global_mask;
    logic                      cur_valid;
    logic [4:0]                cur_id;
    logic                      fast_line;
    logic                      norm_line;
    logic [ICSC_NEV-1:0]       ev_stat;
    logic [ICSC_NEV-1:0]       ev_mask;
  } icsc_state_t;

endpackage
`default_nettype wire

/* File: icsc_top.sv */
// interrupt controller status and command registers behind an AHB-Lite slave
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`default_nettype none
module icsc_top
  import icsc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 srst_in,
  // ahb-lite slave
  input  wire logic                 hsel_in,
  input  wire logic [31:0]          haddr_in,
  input  wire logic [1:0]           htrans_in,
  input  wire logic                 hwrite_in,
  input  wire logic [2:0]           hsize_in,
  input  wire logic [31:0]          hwdata_in,
  input  wire logic                 hready_in,
  output logic      [31:0]          hrdata_out,
  output logic                      hreadyout_out,
  output logic                      hresp_out,
  // interrupt sources, asynchronous, active high
  input  wire logic [ICSC_NSRC-1:0] src_in,
  // core request lines, active low
  output logic                      fast_request_line_n_out,
  output logic                      normal_request_line_n_out,
  // event interrupt
  output logic                      irq_out
);

  icsc_state_t st_reg;
  icsc_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // combinational helpers

  logic [ICSC_NSRC-1:0] act;
  logic [ICSC_NSRC-1:0] rise;
  logic                 norm_any;
  logic [4:0]           norm_id;
  logic                 fast_cur;
  logic                 addr_ok;

  assign act      = st_reg.pending & st_reg.mask;
  // edge capture: only the second and third stages are looked at
  assign rise     = st_reg.src_s2 & ~st_reg.src_s3;
  assign fast_cur = act[0];
  assign addr_ok  = hsel_in & hready_in & htrans_in[1];

  // lowest numbered active normal source wins; no priority levels here
  always_comb begin
    norm_any = 1'b0;
    norm_id  = 5'h00;
    for (int i = ICSC_NSRC - 1; i >= 1; i--) begin
      if (act[i]) begin
        norm_any = 1'b1;
        norm_id  = 5'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [31:0]          wd;
    logic [11:0]          wofs;
    logic                 do_wr;
    logic                 do_rd;
    logic [ICSC_NSRC-1:0] en_c;
    logic [ICSC_NSRC-1:0] dis_c;
    logic [ICSC_NSRC-1:0] clr_c;
    logic [ICSC_NSRC-1:0] set_c;
    logic [ICSC_NSRC-1:0] ack_c;
    logic [ICSC_NEV-1:0]  ev;
    logic [ICSC_NEV-1:0]  ev_clr;
    logic                 nvr_ack;
    logic [31:0]          rd;
    wd      = hwdata_in;
    wofs    = st_reg.aph.ofs;
    do_wr   = (st_reg.bus_st == ICSC_BUS_WR);
    do_rd   = (st_reg.bus_st == ICSC_BUS_RDW);
    en_c    = '0;
    dis_c   = '0;
    clr_c   = '0;
    set_c   = '0;
    ack_c   = '0;
    ev      = '0;
    ev_clr  = '0;
    nvr_ack = 1'b0;
    rd      = ICSC_RST_WORD;
    st_next = st_reg;

    st_next.src_s1 = src_in;
    st_next.src_s2 = st_reg.src_s1;
    st_next.src_s3 = st_reg.src_s2;

    // write data phase
    if (do_wr) begin
      if (wofs >= ICSC_SVR_BASE && wofs <= ICSC_SVR_LAST) begin
        st_next.svr[wofs[6:2]] = wd;
      end
      unique case (wofs)
        ICSC_ENA_OFS: en_c  = wd;
        ICSC_DIS_OFS: dis_c = wd;
        ICSC_CLR_OFS: clr_c = wd;
        ICSC_SET_OFS: set_c = wd;
        ICSC_EOS_OFS: begin
          // data is ignored: the write alone ends service
          st_next.cur_valid = 1'b0;
          ev[ICSC_EV_EOS]   = 1'b1;
        end
        ICSC_SPU_OFS: st_next.spu = wd;
        ICSC_DBG_OFS: begin
          st_next.protect     = wd[ICSC_DBG_PROTECT];
          st_next.global_mask = wd[ICSC_DBG_GLOBAL_MASK];
        end
        // in protection mode a debugger read has no effect; the write commits it
        ICSC_NVR_OFS: nvr_ack = st_reg.protect;
        ICSC_EVS_OFS: ev_clr = wd[ICSC_NEV-1:0];
        ICSC_EVM_OFS: st_next.ev_mask = wd[ICSC_NEV-1:0];
        default: ;
      endcase
    end

    // read data phase, first cycle: value and side effects
    if (do_rd) begin
      if (wofs >= ICSC_SVR_BASE && wofs <= ICSC_SVR_LAST) begin
        rd = st_reg.svr[wofs[6:2]];
      end
      unique case (wofs)
        ICSC_NVR_OFS: begin
          if (st_reg.cur_valid) begin
            rd = st_reg.svr[st_reg.cur_id];
          end else if (norm_any) begin
            rd = st_reg.svr[norm_id];
          end else begin
            rd = st_reg.spu;
          end
          nvr_ack = ~st_reg.protect;
        end
        ICSC_FVR_OFS: begin
          if (fast_cur) begin
            rd = st_reg.svr[0];
            if (!st_reg.protect) begin
              ack_c[0] = 1'b1;
            end
          end else begin
            rd = st_reg.spu;
            ev[ICSC_EV_SPUR] = 1'b1;
          end
        end
        ICSC_CSS_OFS: rd = {27'h0, st_reg.cur_id};
        ICSC_PND_OFS: rd = st_reg.pending;
        ICSC_MSK_OFS: rd = st_reg.mask;
        ICSC_CLS_OFS: begin
          rd[ICSC_CLS_FAST] = st_reg.fast_line;
          rd[ICSC_CLS_NORM] = st_reg.norm_line;
        end
        ICSC_SPU_OFS: rd = st_reg.spu;
        ICSC_DBG_OFS: begin
          rd[ICSC_DBG_PROTECT]     = st_reg.protect;
          rd[ICSC_DBG_GLOBAL_MASK] = st_reg.global_mask;
        end
        ICSC_EVS_OFS: rd[ICSC_NEV-1:0] = st_reg.ev_stat;
        ICSC_EVM_OFS: rd[ICSC_NEV-1:0] = st_reg.ev_mask;
        // command locations and unmapped offsets read zero
        default: ;
      endcase
      st_next.rdata = rd;
    end

    // acknowledge of a normal interrupt makes it current
    if (nvr_ack && !st_reg.cur_valid) begin
      if (norm_any) begin
        st_next.cur_valid = 1'b1;
        st_next.cur_id    = norm_id;
        ack_c[norm_id]    = 1'b1;
      end else begin
        ev[ICSC_EV_SPUR] = 1'b1;
      end
    end

    // all command bits act together; a new edge or set beats any clear
    st_next.mask    = (st_reg.mask | en_c) & ~dis_c;
    st_next.pending = (st_reg.pending & ~clr_c & ~ack_c) | set_c | rise;

    st_next.ev_stat = (st_reg.ev_stat & ~ev_clr) | ev;

    // request lines follow registered state, one cycle behind pending
    st_next.fast_line = fast_cur & ~st_reg.global_mask;
    st_next.norm_line = norm_any & ~st_reg.cur_valid & ~st_reg.global_mask;

    // bus phase sequencing; reads take one wait state so they see prior writes
    unique case (st_reg.bus_st)
      ICSC_BUS_RDW: st_next.bus_st = ICSC_BUS_RDD;
      ICSC_BUS_IDLE, ICSC_BUS_WR, ICSC_BUS_RDD: begin
        if (addr_ok) begin
          st_next.aph.ofs = haddr_in[ICSC_AW-1:0];
          st_next.bus_st  = hwrite_in ? ICSC_BUS_WR : ICSC_BUS_RDW;
        end else begin
          st_next.bus_st  = ICSC_BUS_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      st_reg        <= '0;
      st_reg.bus_st <= ICSC_BUS_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign hrdata_out                = st_reg.rdata;
  assign hreadyout_out             = (st_reg.bus_st != ICSC_BUS_RDW);
  assign hresp_out                 = 1'b0;
  assign fast_request_line_n_out   = ~st_reg.fast_line;
  assign normal_request_line_n_out = ~st_reg.norm_line;
  assign irq_out                   = |(st_reg.ev_stat & st_reg.ev_mask);

endmodule
`default_nettype wire

/* File: icsc_top_properties.sv */
// checker: bus timing, write-only readback, reset state and global mask
`default_nettype none
module icsc_top_properties
  import icsc_pkg::*;
(
  // clock, reset and bus
  input wire logic        clk_sys_in,
  input wire logic        srst_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // core lines and event interrupt
  input wire logic        fast_request_line_n_out,
  input wire logic        normal_request_line_n_out,
  input wire logic        irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic rd_wo_reg;
  logic wr_dbg_reg;
  assign take = hsel_in && hready_in && htrans_in[1];
  // data-phase flags, so checks can look at the phase after the address
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rd_wo_reg  <= 1'b0;
      wr_dbg_reg <= 1'b0;
    end else begin
      rd_wo_reg  <= take && !hwrite_in && haddr_in[11:0] >= ICSC_ENA_OFS
                    && haddr_in[11:0] <= ICSC_EOS_OFS;
      wr_dbg_reg <= take && hwrite_in && haddr_in[11:0] == ICSC_DBG_OFS;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  property p_resp; hresp_out == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("response not okay");
  property p_rd_wait; take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait not exactly one");
  property p_wr_nowait; take && hwrite_in |=> hreadyout_out; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_hold; hreadyout_out |=> $stable(hrdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved outside a read");
  property p_wo_zero; rd_wo_reg |=> hrdata_out == 32'h0; endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("command offset read nonzero");
  property p_global_mask;
    wr_dbg_reg && hwdata_in[1] |=> ##[0:2] (fast_request_line_n_out && normal_request_line_n_out);
  endproperty
  a_global_mask: assert property (p_global_mask) else $error("lines active under global mask");
  property p_rst;
    $fell(srst_in) |-> hreadyout_out && !irq_out && hrdata_out == 32'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  property p_quiet;
    $fell(srst_in) |-> (fast_request_line_n_out && normal_request_line_n_out)[*3];
  endproperty
  a_quiet: assert property (p_quiet) else $error("core line active right after reset");
  c_rd: cover property (take && !hwrite_in);
  c_global_mask: cover property (wr_dbg_reg && hwdata_in[1]);
  c_wo: cover property (rd_wo_reg);
endmodule
`default_nettype wire

/* File: icsc_core_model.sv */
// partner: processor core sampling the active-low request lines
`default_nettype none
module icsc_core_model (
  // clock and active-low request lines in, registered line state out
  input wire logic clk_in,
  input wire logic fast_n_in,
  input wire logic norm_n_in,
  output var logic fast_act_out,
  output var logic norm_act_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // the core registers its request inputs, it does not react combinationally
  always_ff @(posedge clk_in) begin
    fast_act_out <= !fast_n_in;
    norm_act_out <= !norm_n_in;
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// testbench: register and vector scenarios over the bus
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import icsc_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        hsel = 1'b0, hwrite = 1'b0, hrdy, hresp, fn, nn, irq, fa, na;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = '0, hwdata = '0, src = '0, hrdata, q;
  int          err_count = 0, checks_done = 0, cyc = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  icsc_top i_dut (.clk_sys_in, .srst_in, .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hrdy),
    .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .src_in(src),
    .fast_request_line_n_out(fn), .normal_request_line_n_out(nn), .irq_out(irq));
  icsc_core_model i_core (.clk_in(clk_sys_in), .fast_n_in(fn), .norm_n_in(nn),
    .fast_act_out(fa), .norm_act_out(na));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single transfer; signals sampled in the edge's own event, before updates land
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clk_sys_in iff hrdy === 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk_sys_in iff hrdy === 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic ck_irq(input logic e);
    repeat (2) @(posedge clk_sys_in);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic endt(input string n);
    $display("test %s done", n);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rc(ICSC_PND_OFS, 32'h0);
    rc(ICSC_MSK_OFS, 32'h0);
    rc(ICSC_CLS_OFS, 32'h0);
    rc(ICSC_CSS_OFS, 32'h0);
    rc(ICSC_DBG_OFS, 32'h0);
    for (int i = 0; i < 5; i++) rc(ICSC_ENA_OFS + 12'(4 * i), 32'h0);
    rc(12'h118, 32'h0);
    endt("reset");
    wr(ICSC_SPU_OFS, 32'ha5a5_0001);
    rc(ICSC_SPU_OFS, 32'ha5a5_0001);
    rc(ICSC_FVR_OFS, 32'ha5a5_0001);
    rc(ICSC_NVR_OFS, 32'ha5a5_0001);
    endt("spurious");
    wr(ICSC_ENA_OFS, 32'h0000_00f2);
    wr(ICSC_ENA_OFS, 32'h0000_0005);
    rc(ICSC_MSK_OFS, 32'h0000_00f7);
    wr(ICSC_DIS_OFS, 32'h0000_0003);
    rc(ICSC_MSK_OFS, 32'h0000_00f4);
    wr(ICSC_SET_OFS, 32'h8000_0006);
    rc(ICSC_PND_OFS, 32'h8000_0006);
    wr(ICSC_CLR_OFS, 32'h0000_0002);
    rc(ICSC_PND_OFS, 32'h8000_0004);
    endt("commands");
    wr(ICSC_SVR_BASE, 32'h1000_0000);
    wr(ICSC_SVR_BASE + 12'h008, 32'h2000_0002);
    wr(ICSC_ENA_OFS, 32'h0000_0001);
    wr(ICSC_SET_OFS, 32'h0000_0001);
    rc(ICSC_CLS_OFS, 32'h0000_0003);
    chk({30'h0, na, fa}, 32'h3);
    rc(ICSC_FVR_OFS, 32'h1000_0000);
    rc(ICSC_PND_OFS, 32'h8000_0004);
    rc(ICSC_NVR_OFS, 32'h2000_0002);
    rc(ICSC_CSS_OFS, 32'h0000_0002);
    rc(ICSC_CLS_OFS, 32'h0000_0000);
    rc(ICSC_NVR_OFS, 32'h2000_0002);
    wr(ICSC_EOS_OFS, 32'h0000_dead);
    rc(ICSC_NVR_OFS, 32'ha5a5_0001);
    endt("vectors");
    wr(ICSC_SET_OFS, 32'h0000_0004);
    wr(ICSC_DBG_OFS, 32'h0000_0002);
    rc(ICSC_DBG_OFS, 32'h0000_0002);
    rc(ICSC_CLS_OFS, 32'h0000_0000);
    chk({30'h0, na, fa}, 32'h0);
    wr(ICSC_DBG_OFS, 32'h0000_0001);
    rc(ICSC_CLS_OFS, 32'h0000_0002);
    rc(ICSC_NVR_OFS, 32'h2000_0002);
    rc(ICSC_PND_OFS, 32'h8000_0004);
    wr(ICSC_NVR_OFS, 32'h0000_0000);
    rc(ICSC_PND_OFS, 32'h8000_0000);
    wr(ICSC_EOS_OFS, 32'h0000_0000);
    wr(ICSC_DBG_OFS, 32'h0000_0000);
    endt("debug");
    @(posedge clk_sys_in);
    src <= 32'h0000_0008;
    repeat (6) @(posedge clk_sys_in);
    rc(ICSC_PND_OFS, 32'h8000_0008);
    endt("source");
    wr(ICSC_EVS_OFS, 32'h0000_0003);
    wr(ICSC_EVM_OFS, 32'h0000_0001);
    wr(ICSC_EOS_OFS, 32'h0000_0000);
    ck_irq(1'b1);
    rc(ICSC_EVS_OFS, 32'h0000_0001);
    wr(ICSC_EVM_OFS, 32'h0000_0000);
    ck_irq(1'b0);
    wr(ICSC_EVM_OFS, 32'h0000_0001);
    ck_irq(1'b1);
    wr(ICSC_EVS_OFS, 32'h0000_0001);
    ck_irq(1'b0);
    endt("events");
    srst_in <= 1'b1;
    src <= '0;
    repeat (8) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    rc(ICSC_PND_OFS, 32'h0);
    rc(ICSC_SPU_OFS, 32'h0);
    rc(ICSC_DBG_OFS, 32'h0);
    endt("reset again");
    finish_test();
  end
endmodule
bind icsc_top icsc_top_properties i_chk (.clk_sys_in, .srst_in, .hsel_in, .haddr_in,
  .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
  .fast_request_line_n_out, .normal_request_line_n_out, .irq_out);
`default_nettype wire
